// ---- ddrsp_pkg.sv ----
// Function
// - Separate read output and write input buses
// - Two words move per address, always
// - Read address captured on main clock rise
// - Write address captured on inverted clock rise
// - Data words move on both clock rises
// - Controller keeps clock pair at most 250 MHz
// - First read word two cycles after address
// - Controller multiplexes addresses onto shared bus
// - Independent read and write port selects
// - Writes complete internally, no write strobe
// - All synchronous inputs but the second write word pass input registers
// - Read data launched from output registers
// - Reads return most recently written data
// - Echo clock pair aligned with read data
// - Only rising edges of input clocks used
// - Data width fixed per device, 18 or 36
package ddrsp_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int WORD_W      = 18;        // Narrow configuration
  localparam int WORD_W_WIDE = 36;        // Wide configuration, alternative build
  localparam int BURST_LEN   = 2;         // Words per address
  localparam int ADDR_W      = 10;        // Modelled depth
  localparam int DEPTH       = 1 << ADDR_W;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ     = 250;       // Controller clock rate
  localparam int K_MAX_MHZ   = 250;       // Highest clock pair rate
  localparam int K_DIV       = 2;         // Controller cycles per link cycle
  localparam int RD_LAT_CYC  = 2;         // Link cycles, address to first word
  localparam int RD_PIPE_W   = K_DIV * RD_LAT_CYC + 3;
  localparam int RD_CAP0     = K_DIV * RD_LAT_CYC + 1;
  localparam int RD_CAP1     = K_DIV * RD_LAT_CYC + 2;
  localparam int LOCK_W      = 11;
  localparam logic [LOCK_W-1:0] LOCK_CYC     = 11'h400;
  localparam logic [LOCK_W-1:0] LINK_RST_CYC = 11'h010;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic SEL_IDLE_N = 1'h1;     // Port deselected

endpackage

// ---- ddrsp_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface ddrsp_if;
  logic                        k;
  logic                        k_n;
  logic                        link_rst_n;
  logic [ddrsp_pkg::ADDR_W-1:0] addr;
  logic                        rd_sel_n;
  logic                        wr_sel_n;
  logic [ddrsp_pkg::WORD_W-1:0] wdata;
  logic [ddrsp_pkg::WORD_W-1:0] q_rise;
  logic [ddrsp_pkg::WORD_W-1:0] q_fall;
  logic                        echo_tog_k;
  logic                        echo_tog_kb;
  logic [ddrsp_pkg::WORD_W-1:0] q;
  logic                        echo_clock_pair_p;
  logic                        echo_clock_pair_n;

  // Wire level of the read bus and echo pair, echo high in the main clock's high half
  assign q                 = k ? q_rise : q_fall;
  assign echo_clock_pair_p = ~(echo_tog_k ^ echo_tog_kb);
  assign echo_clock_pair_n = echo_tog_k ^ echo_tog_kb;

  modport dev (
    input  k, k_n, link_rst_n, addr, rd_sel_n, wr_sel_n, wdata,
    output q_rise, q_fall, echo_tog_k, echo_tog_kb
  );
  modport host (
    output k, k_n, link_rst_n, addr, rd_sel_n, wr_sel_n, wdata,
    input  q_rise, q_fall, echo_clock_pair_p, echo_clock_pair_n
  );
endinterface
`default_nettype wire

// ---- ddrsp_dev.sv ----
`timescale 1ns/1ps
`default_nettype none
module ddrsp_dev (
  // Link to controller
  ddrsp_if.dev  lnk,
  // Status
  output logic  dev_active_o
);

  localparam int W = ddrsp_pkg::WORD_W;
  localparam int A = ddrsp_pkg::ADDR_W;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [1:0]   rst_sync;
    logic [A-1:0] ra1;
    logic         rv1;
    logic [A-1:0] ra2;
    logic         rv2;
    logic [W-1:0] w0;
    logic [W-1:0] q_rise;
    logic [W-1:0] q1_hold;
    logic         echo_tog;
  } ddrsp_dk_s;

  typedef struct packed {
    logic [A-1:0] wa;
    logic         wact;
    logic [W-1:0] q_fall;
    logic         echo_tog;
  } ddrsp_db_s;

  ddrsp_dk_s dk_r, dk_nxt;
  ddrsp_db_s db_r, db_nxt;
  logic [ddrsp_pkg::BURST_LEN*W-1:0] mem [ddrsp_pkg::DEPTH];
  logic active;

  assign active = dk_r.rst_sync[1];

  // ****************************************************************
  // Main clock rise: read address, first write word, first read word
  // ****************************************************************
  always_comb
  begin
    dk_nxt          = '0;
    dk_nxt.rst_sync = {dk_r.rst_sync[0], lnk.link_rst_n};
    if (active)
    begin
      dk_nxt.ra1      = lnk.addr;
      dk_nxt.rv1      = ~lnk.rd_sel_n;
      dk_nxt.ra2      = dk_r.ra1;
      dk_nxt.rv2      = dk_r.rv1;
      dk_nxt.w0       = lnk.wdata;
      dk_nxt.q_rise   = dk_r.q_rise;
      dk_nxt.q1_hold  = dk_r.q1_hold;
      // Memory is read late so every earlier write has landed
      if (dk_r.rv2)
      begin
        dk_nxt.q_rise  = mem[dk_r.ra2][W-1:0];
        dk_nxt.q1_hold = mem[dk_r.ra2][2*W-1:W];
      end
      dk_nxt.echo_tog = ~dk_r.echo_tog;
    end
  end

  // Rising edge only
  always_ff @(posedge lnk.k)
  begin
    dk_r <= dk_nxt;
  end

  // ****************************************************************
  // Inverted clock rise: write address, second words, commit
  // ****************************************************************
  always_comb
  begin
    db_nxt = '0;
    if (active)
    begin
      db_nxt.wa       = lnk.addr;
      db_nxt.wact     = ~lnk.wr_sel_n;
      db_nxt.q_fall   = dk_r.q1_hold;
      db_nxt.echo_tog = ~db_r.echo_tog;
    end
  end

  // Rising edge of the inverted clock only
  always_ff @(posedge lnk.k_n)
  begin
    db_r <= db_nxt;
  end

  // Self-timed write of both words once the second arrives
  always_ff @(posedge lnk.k_n)
  begin
    if (active && db_r.wact)
    begin
      mem[db_r.wa] <= {lnk.wdata, dk_r.w0};
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign lnk.q_rise      = dk_r.q_rise;
  assign lnk.q_fall      = db_r.q_fall;
  assign lnk.echo_tog_k  = dk_r.echo_tog;
  assign lnk.echo_tog_kb = db_r.echo_tog;
  assign dev_active_o    = dk_r.rst_sync[1];

endmodule // ddrsp_dev
`default_nettype wire

// ---- ddrsp_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module ddrsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } ddrsp_fifo_s;

  ddrsp_fifo_s st_r, st_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // Handshakes and honest full and empty
  assign in_ready_o  = (st_r.cnt != DEPTH[AW:0]);
  assign out_valid_o = (st_r.cnt != '0);
  assign out_data_o  = mem[st_r.rp];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Pointer and count update
  always_comb
  begin
    st_nxt = st_r;
    if (push)
    begin
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (pop)
    begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
    if (push && !pop)
    begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
    else if (pop && !push)
    begin
      st_nxt.cnt = st_r.cnt - 1'b1;
    end
    if (!rst_n_i)
    begin
      st_nxt = '0;
    end
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    st_r <= st_nxt;
  end

  // Storage
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem[st_r.wp] <= in_data_i;
    end
  end

endmodule // ddrsp_fifo

module ddrsp_host (
  // Clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_n_i,
  // Link to device
  ddrsp_if.host                              lnk,
  // Read requests
  input  wire logic                          rd_req_i,
  input  wire logic [ddrsp_pkg::ADDR_W-1:0]  rd_addr_i,
  output logic                               rd_ready_o,
  // Read results
  output logic                               rd_valid_o,
  output logic [ddrsp_pkg::WORD_W-1:0]       rd_data0_o,
  output logic [ddrsp_pkg::WORD_W-1:0]       rd_data1_o,
  // Write requests
  input  wire logic                          wr_valid_i,
  input  wire logic [ddrsp_pkg::ADDR_W-1:0]  wr_addr_i,
  input  wire logic [ddrsp_pkg::WORD_W-1:0]  wr_data0_i,
  input  wire logic [ddrsp_pkg::WORD_W-1:0]  wr_data1_i,
  output logic                               wr_ready_o,
  // Status
  output logic                               link_ready_o,
  output logic                               link_alive_o
);

  localparam int W  = ddrsp_pkg::WORD_W;
  localparam int A  = ddrsp_pkg::ADDR_W;
  localparam int FW = A + 2 * W;
  localparam int PW = ddrsp_pkg::RD_PIPE_W;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic                          k;
    logic                          kn;
    logic [ddrsp_pkg::LOCK_W-1:0]  lock_cnt;
    logic                          lock_done;
    logic                          link_rst_n;
    logic [A-1:0]                  addr;
    logic                          rd_sel_n;
    logic                          wr_sel_n;
    logic [W-1:0]                  wdata;
    logic [W-1:0]                  w0_hold;
    logic [W-1:0]                  w1_hold;
    logic                          rd_ready;
    logic [PW-1:0]                 rd_pipe;
    logic [W-1:0]                  rd_d0;
    logic [W-1:0]                  rd_d1;
    logic                          rd_valid;
    logic [2:0]                    echo_sync;
    logic                          echo_seen;
  } ddrsp_host_s;

  // Link pins, launched half a cycle away from the clock pair edges
  typedef struct packed {
    logic                          link_rst_n;
    logic [A-1:0]                  addr;
    logic                          rd_sel_n;
    logic                          wr_sel_n;
    logic [W-1:0]                  wdata;
  } ddrsp_launch_s;

  ddrsp_host_s hq_r, hq_nxt;
  ddrsp_launch_s lp_r;
  logic          fifo_valid;
  logic          fifo_ready;
  logic [FW-1:0] fifo_data;
  logic          rd_take;

  // Write burst queue, drained only in write address slots
  ddrsp_fifo #(
    .WIDTH (FW),
    .DEPTH (16)
  ) u_wr_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (wr_valid_i),
    .in_ready_o  (wr_ready_o),
    .in_data_i   ({wr_addr_i, wr_data1_i, wr_data0_i}),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_ready),
    .out_data_o  (fifo_data)
  );

  assign fifo_ready = hq_r.lock_done & ~hq_r.k;
  assign rd_take    = rd_req_i & hq_r.rd_ready;

  // ****************************************************************
  // Clock pair, slots and read capture
  // ****************************************************************
  always_comb
  begin
    hq_nxt           = hq_r;
    hq_nxt.k         = ~hq_r.k;
    hq_nxt.kn        = hq_r.k;
    hq_nxt.lock_done = (hq_r.lock_cnt == ddrsp_pkg::LOCK_CYC);
    if (!hq_nxt.lock_done)
    begin
      hq_nxt.lock_cnt = hq_r.lock_cnt + 11'h001;
    end
    hq_nxt.link_rst_n = (hq_r.lock_cnt >= ddrsp_pkg::LINK_RST_CYC);
    hq_nxt.rd_ready   = hq_r.lock_done & ~hq_r.k;
    hq_nxt.rd_pipe    = {hq_r.rd_pipe[PW-2:0], rd_take};
    if (!hq_r.k)
    begin
      // Main clock rises next: write address slot and second word
      hq_nxt.wr_sel_n = ~(fifo_valid & fifo_ready);
      hq_nxt.wdata    = hq_r.w1_hold;
      if (fifo_valid && fifo_ready)
      begin
        hq_nxt.addr    = fifo_data[FW-1:2*W];
        hq_nxt.w1_hold = fifo_data[2*W-1:W];
        hq_nxt.w0_hold = fifo_data[W-1:0];
      end
    end
    else
    begin
      // Inverted clock rises next: read address slot and first word
      hq_nxt.rd_sel_n = ~rd_take;
      hq_nxt.wdata    = hq_r.w0_hold;
      if (rd_take)
      begin
        hq_nxt.addr = rd_addr_i;
      end
    end
    // Fixed latency capture of both read words
    if (hq_r.rd_pipe[ddrsp_pkg::RD_CAP0])
    begin
      hq_nxt.rd_d0 = lnk.q_rise;
    end
    if (hq_r.rd_pipe[ddrsp_pkg::RD_CAP1])
    begin
      hq_nxt.rd_d1 = lnk.q_fall;
    end
    hq_nxt.rd_valid  = hq_r.rd_pipe[ddrsp_pkg::RD_CAP1];
    // Echo clock watched through two flops before use
    hq_nxt.echo_sync = {hq_r.echo_sync[1:0], lnk.echo_clock_pair_p};
    if (hq_r.echo_sync[2] != hq_r.echo_sync[1])
    begin
      hq_nxt.echo_seen = 1'h1;
    end
    if (!rst_n_i)
    begin
      hq_nxt          = '0;
      hq_nxt.rd_sel_n = ddrsp_pkg::SEL_IDLE_N;
      hq_nxt.wr_sel_n = ddrsp_pkg::SEL_IDLE_N;
    end
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    hq_r <= hq_nxt;
  end

  // Falling edge launch keeps pins settled at every clock pair rise
  always_ff @(negedge clk_i)
  begin
    lp_r.link_rst_n <= hq_r.link_rst_n;
    lp_r.addr       <= hq_r.addr;
    lp_r.rd_sel_n   <= hq_r.rd_sel_n;
    lp_r.wr_sel_n   <= hq_r.wr_sel_n;
    lp_r.wdata      <= hq_r.wdata;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign lnk.k          = hq_r.k;
  assign lnk.k_n        = hq_r.kn;
  assign lnk.link_rst_n = lp_r.link_rst_n;
  assign lnk.addr       = lp_r.addr;
  assign lnk.rd_sel_n   = lp_r.rd_sel_n;
  assign lnk.wr_sel_n   = lp_r.wr_sel_n;
  assign lnk.wdata      = lp_r.wdata;
  assign rd_ready_o     = hq_r.rd_ready;
  assign rd_valid_o     = hq_r.rd_valid;
  assign rd_data0_o     = hq_r.rd_d0;
  assign rd_data1_o     = hq_r.rd_d1;
  assign link_ready_o   = hq_r.lock_done;
  assign link_alive_o   = hq_r.echo_seen;

endmodule // ddrsp_host
`default_nettype wire

// ---- ddrsp_link_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module ddrsp_link_monitor (
  // Link clocks and reset
  input wire logic                         k,
  input wire logic                         k_n,
  input wire logic                         link_rst_n,
  // Read port
  input wire logic                         rd_sel_n,
  input wire logic [ddrsp_pkg::WORD_W-1:0] q_rise,
  input wire logic [ddrsp_pkg::WORD_W-1:0] q_fall,
  // Echo clocks
  input wire logic                         echo_tog_k,
  input wire logic                         echo_clock_pair_p,
  input wire logic                         echo_clock_pair_n
);
  // ********
  // Clock pair phase
  // ********
  a_pair_phase_k: assert property (@(posedge k) disable iff (!link_rst_n) k_n)
    else $error("inverted clock not high before main rise");
  a_pair_phase_kn: assert property (@(posedge k_n) disable iff (!link_rst_n) k)
    else $error("main clock not high before inverted rise");

  // ********
  // Read words only after a selected read, two cycles on
  // ********
  a_word0_after_sel: assert property (@(posedge k) disable iff (!link_rst_n)
    $changed(q_rise) |-> !$past(rd_sel_n, 3))
    else $error("first read word moved without a read two cycles before");
  a_word1_after_sel: assert property (@(posedge k) disable iff (!link_rst_n)
    $changed(q_fall) |-> !$past(rd_sel_n, 3))
    else $error("second read word moved without a read two cycles before");

  // ********
  // Echo clocks
  // ********
  a_echo_pair_comp: assert property (@(posedge k) disable iff (!link_rst_n)
    echo_clock_pair_n == !echo_clock_pair_p)
    else $error("echo pair not complementary");
  a_echo_toggles: assert property (@(posedge k) disable iff (!link_rst_n)
    $past(link_rst_n, 8) |-> $changed(echo_tog_k))
    else $error("echo toggle stalled");
  a_echo_low_k: assert property (@(posedge k) disable iff (!link_rst_n)
    $past(link_rst_n, 8) |-> !echo_clock_pair_p)
    else $error("echo high in low half");
  a_echo_high_kn: assert property (@(posedge k_n) disable iff (!link_rst_n)
    $past(link_rst_n, 8) |-> echo_clock_pair_p)
    else $error("echo low in high half");
endmodule // ddrsp_link_monitor
`default_nettype wire

// ---- ddrsp_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin fails++; $display("ERROR %s exp %0h got %0h", nm, ex, got); end end
module ddrsp_tb_top;
  localparam int AW  = ddrsp_pkg::ADDR_W;
  localparam int WW  = ddrsp_pkg::WORD_W;
  localparam int TMO = 20000;
  // ********
  // Clock, reset and user side
  // ********
  logic            clk_i      = 1'b0;
  logic            rst_n_i    = 1'b0;
  logic            rd_req_i   = 1'b0;
  logic [AW-1:0]   rd_addr_i  = '0;
  logic            wr_valid_i = 1'b0;
  logic [AW-1:0]   wr_addr_i  = '0;
  logic [WW-1:0]   wr_data0_i = '0;
  logic [WW-1:0]   wr_data1_i = '0;
  logic            rd_ready_o;
  logic            rd_valid_o;
  logic [WW-1:0]   rd_data0_o;
  logic [WW-1:0]   rd_data1_o;
  logic            wr_ready_o;
  logic            link_ready_o;
  logic            link_alive_o;
  logic            dev_active_o;
  int              fails      = 0;
  int              checked    = 0;
  int              cyc        = 0;
  int              refused    = 0;
  logic [2*WW-1:0] mem [0:1023];
  logic [2*WW-1:0] exp_q [$];
  logic [2*WW-1:0] got_q [$];
  int              take_q [$];
  int              lat_q [$];

  // Host clock
  always #2 clk_i = ~clk_i;

  // ********
  // Both ends and the link checker
  // ********
  ddrsp_if i_ddrsp_if ();
  ddrsp_dev i_ddrsp_dev (.lnk(i_ddrsp_if), .dev_active_o(dev_active_o));
  ddrsp_host i_ddrsp_host (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .lnk(i_ddrsp_if),
    .rd_req_i(rd_req_i), .rd_addr_i(rd_addr_i), .rd_ready_o(rd_ready_o),
    .rd_valid_o(rd_valid_o), .rd_data0_o(rd_data0_o), .rd_data1_o(rd_data1_o),
    .wr_valid_i(wr_valid_i), .wr_addr_i(wr_addr_i), .wr_data0_i(wr_data0_i),
    .wr_data1_i(wr_data1_i), .wr_ready_o(wr_ready_o),
    .link_ready_o(link_ready_o), .link_alive_o(link_alive_o)
  );
  ddrsp_link_monitor i_ddrsp_link_monitor (
    .k(i_ddrsp_if.k), .k_n(i_ddrsp_if.k_n), .link_rst_n(i_ddrsp_if.link_rst_n),
    .rd_sel_n(i_ddrsp_if.rd_sel_n), .q_rise(i_ddrsp_if.q_rise), .q_fall(i_ddrsp_if.q_fall),
    .echo_tog_k(i_ddrsp_if.echo_tog_k), .echo_clock_pair_p(i_ddrsp_if.echo_clock_pair_p),
    .echo_clock_pair_n(i_ddrsp_if.echo_clock_pair_n)
  );

  // Collects read results with latency, cuts a hang short
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (rd_valid_o === 1'b1)
    begin
      got_q.push_back({rd_data0_o, rd_data1_o});
      lat_q.push_back(cyc - take_q.pop_front());
    end
    if (cyc == TMO)
    begin
      fails++;
      end_of_test();
    end
  end

  // ********
  // Shared tasks
  // ********
  // Pushes one burst, waiting out back-pressure
  task automatic push_wr(input logic [AW-1:0] a, input logic [WW-1:0] d0);
    wr_valid_i = 1'b1;
    wr_addr_i  = a;
    wr_data0_i = d0;
    wr_data1_i = ~d0;
    mem[a]     = {d0, ~d0};
    @(posedge clk_i);
    while (wr_ready_o !== 1'b1)
    begin
      refused++;
      @(posedge clk_i);
    end
    #1;
  endtask

  // Holds a read request until taken, request stays up
  task automatic issue_rd(input logic [AW-1:0] a);
    rd_req_i  = 1'b1;
    rd_addr_i = a;
    do @(posedge clk_i); while (rd_ready_o !== 1'b1);
    take_q.push_back(cyc);
    exp_q.push_back(mem[a]);
    #1;
  endtask

  // Idles the user side and judges all reads
  task automatic settle();
    logic [2*WW-1:0] e;
    logic [2*WW-1:0] g;
    int              l;
    rd_req_i   = 1'b0;
    wr_valid_i = 1'b0;
    repeat (40) @(posedge clk_i);
    #1;
    `CHK("read count", exp_q.size(), got_q.size())
    while (exp_q.size() != 0 && got_q.size() != 0)
    begin
      e = exp_q.pop_front();
      g = got_q.pop_front();
      l = lat_q.pop_front();
      `CHK("read words", e, g)
      `CHK("read latency", 8, l)
    end
    exp_q.delete();
    got_q.delete();
  endtask

  // Waits for lock and checks link status
  task automatic wait_ready();
    int n;
    n = 0;
    while (link_ready_o !== 1'b1 && n < 3000)
    begin
      @(posedge clk_i);
      n++;
    end
    #1;
    `CHK("link ready", 1'b1, link_ready_o)
    `CHK("echo seen", 1'b1, link_alive_o)
    `CHK("device active", 1'b1, dev_active_o)
  endtask

  // ********
  // Scenarios
  // ********
  // Address extremes, read back after both writes have landed
  task automatic t_basic();
    push_wr(10'h000, 18'h0_a5a5);
    push_wr(10'h3ff, 18'h3_5a5a);
    wr_valid_i = 1'b0;
    repeat (6) @(posedge clk_i);
    #1;
    issue_rd(10'h000);
    issue_rd(10'h3ff);
    settle();
  endtask

  // Floods the write queue, reads during the drain, then the last values
  task automatic t_fill();
    refused = 0;
    for (int i = 0; i < 40; i++)
      push_wr(AW'(4 + i % 4), WW'(i * 7 + 1));
    wr_valid_i = 1'b0;
    `CHK("write back-pressure", 1'b1, refused > 0)
    issue_rd(10'h000);
    issue_rd(10'h3ff);
    settle();
    for (int i = 4; i < 8; i++)
      issue_rd(AW'(i));
    settle();
  endtask

  // Reset in mid-run, then a fresh lock
  task automatic t_reset();
    rst_n_i = 1'b0;
    repeat (20) @(posedge clk_i);
    #1;
    `CHK("link ready in reset", 1'b0, link_ready_o)
    `CHK("write ready in reset", 1'b1, wr_ready_o)
    rst_n_i = 1'b1;
    wait_ready();
  endtask

  // Prints counts and verdict, ends the run
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    wait_ready();
    t_basic();
    t_fill();
    t_reset();
    t_basic();
    end_of_test();
  end
endmodule // ddrsp_tb_top
`default_nettype wire
